// >>> smrfc_pkg.sv
// shared constants and types for the supply monitor, reset and fault capture block
package smrfc_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_PERIOD_NS = 10;
  // converter pacing: gap step and single conversion time
  localparam int GAP_STEP_NS = 250;
  localparam int CONV_NS = 1750;
  localparam int TICK_CYCLES = (GAP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TICKS = (CONV_NS + GAP_STEP_NS - 1) / GAP_STEP_NS;
  // reset hold delay step unit, scaled by the monitor sample interval
  localparam int RESET_STEP_NS = 100000;
  localparam int RESET_STEP_CYCLES = (RESET_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [2:0] LAST_PHASE = 3'h4;
  localparam logic [2:0] CONVS_FILTERED = 3'h4;
  localparam logic [2:0] CONVS_UNFILTERED = 3'h1;

  // command codes
  localparam logic [7:0] CMD_RESET_HOLD_DELAY = 8'hdd;
  localparam logic [7:0] CMD_ADC_GAP_INTERVAL = 8'hdf;
  localparam logic [7:0] CMD_DAC_UPDATE_SAMPLE_COUNT = 8'he0;
  localparam logic [7:0] CMD_RESET_SOURCE_SELECT = 8'he1;
  localparam logic [7:0] CMD_FAULT_CAUSE_FLAGS = 8'he2;
  localparam logic [7:0] CMD_FAULT_VOLTAGE_SNAPSHOT = 8'he3;
  localparam logic [7:0] CMD_FAULT_TEMPERATURE_SNAPSHOT = 8'he4;

  // reset values
  localparam logic [15:0] GAP_INTERVAL_RST = 16'h0064;
  localparam logic [15:0] DAC_COUNT_RST = 16'h0001;
  localparam logic [7:0] RESET_SELECT_RST = 8'hff;
  localparam logic [15:0] HOLD_DELAY_RST = 16'h0000;

  // field positions
  localparam int FLAG_STRIDE = 4;
  localparam int OVER_FLAG_BIT = 0;
  localparam int UNDER_FLAG_BIT = 1;
  localparam int SPREAD_ENABLE_BIT = 4;
  localparam int FILTER_OFF_BIT = 1;
  localparam logic [7:0] LAST_CHANNEL = 8'h03;

  typedef enum logic [1:0] {
    SEQ_CONV = 2'b00,
    SEQ_GAP = 2'b01
  } smrfc_seq_state_type;

  typedef enum logic [1:0] {
    RST_HOLD = 2'b00,
    RST_WAIT = 2'b01,
    RST_RELEASED = 2'b11
  } smrfc_rst_state_type;
endpackage

// >>> smrfc_seq_if.sv
// link between the register core and the conversion sequencer
`timescale 1ns/10ps
interface smrfc_seq_if;
  logic [15:0] gap_interval;
  logic [15:0] dac_count;
  logic filter_on;
  logic trim_on;
  logic conv_done;
  logic seq_done;
  logic dac_update;
  modport ctrl (
    output gap_interval, dac_count, filter_on, trim_on,
    input conv_done, seq_done, dac_update
  );
  modport seq (
    input gap_interval, dac_count, filter_on, trim_on,
    output conv_done, seq_done, dac_update
  );
endinterface

// >>> smrfc_sequencer.sv
// monitor conversion sequencer and trim update pacing
`timescale 1ns/10ps
module smrfc_sequencer
  import smrfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  smrfc_seq_if.seq link
);
  typedef struct packed {
    logic [4:0] div;
    smrfc_seq_state_type st;
    logic [2:0] phase;
    logic [2:0] conv_idx;
    logic [15:0] tick_cnt;
    logic [15:0] samp_cnt;
    logic conv_done;
    logic seq_done;
    logic dac_update;
  } smrfc_seq_regs_type;

  smrfc_seq_regs_type r, nxt;
  logic tick_en;
  logic [2:0] convs;
  logic [15:0] dac_target;

  assign tick_en = (r.div == 5'(TICK_CYCLES - 1));
  assign convs = link.filter_on ? CONVS_FILTERED : CONVS_UNFILTERED;
  // a zero count would never update; treat it as one sample
  assign dac_target = (link.dac_count == 16'h0000) ? 16'h0001 : link.dac_count;

  always_comb begin
    nxt = r;
    nxt.conv_done = 1'b0;
    nxt.seq_done = 1'b0;
    nxt.dac_update = 1'b0;
    nxt.div = tick_en ? 5'h00 : r.div + 5'h01;
    if (tick_en) begin
      case (r.st)
        SEQ_CONV: begin
          if (r.tick_cnt == 16'(CONV_TICKS - 1)) begin
            nxt.conv_done = 1'b1;
            nxt.tick_cnt = 16'h0000;
            if (r.phase == 3'h0) begin
              nxt.st = SEQ_GAP;
            // a filter switch mid-phase must not let the index run past the last conversion
            end else if (r.conv_idx >= convs - 3'h1) begin
              nxt.conv_idx = 3'h0;
              if (r.phase == LAST_PHASE) begin
                nxt.seq_done = 1'b1;
                nxt.phase = 3'h0;
                if (link.trim_on) begin
                  if (r.samp_cnt + 16'h0001 >= dac_target) begin
                    nxt.dac_update = 1'b1;
                    nxt.samp_cnt = 16'h0000;
                  end else begin
                    nxt.samp_cnt = r.samp_cnt + 16'h0001;
                  end
                end else begin
                  nxt.samp_cnt = 16'h0000;
                end
              end else begin
                nxt.phase = r.phase + 3'h1;
                nxt.st = SEQ_GAP;
              end
            end else begin
              nxt.conv_idx = r.conv_idx + 3'h1;
            end
          end else begin
            nxt.tick_cnt = r.tick_cnt + 16'h0001;
          end
        end
        SEQ_GAP: begin
          // gap of N steps of 250 ns; N of zero gives a one-step gap, the same as N of one
          if (r.tick_cnt + 16'h0001 >= link.gap_interval) begin
            nxt.tick_cnt = 16'h0000;
            if (r.phase == 3'h0) begin
              nxt.phase = 3'h1;
            end else begin
              nxt.st = SEQ_CONV;
            end
          end else begin
            nxt.tick_cnt = r.tick_cnt + 16'h0001;
          end
        end
        default: begin
          nxt.st = SEQ_CONV;
          nxt.phase = 3'h0;
          nxt.tick_cnt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign link.conv_done = r.conv_done;
  assign link.seq_done = r.seq_done;
  assign link.dac_update = r.dac_update;
endmodule // smrfc_sequencer

// >>> smrfc_top.sv
// supply monitor: converter pacing, supervised reset output and fault capture
//
// Contract
// - gap between conversions is value times 250ns
// - gap value loads 100 at power-up
// - sequence: conversion, gap, four gap-plus-conversion phases
// - result registers refresh once per sequence
// - trim updates after programmed sample count
// - trim period follows sequence time times count
// - reset open-drain, low during power-on
// - valid channel releases reset after hold delay
// - invalid select keeps reset low forever
// - selected channel disabled drives reset low
// - flags word: over 4n, under 4n+1
// - under flag when voltage below limit
// - over flag when voltage above limit
// - voltage snapshot taken at voltage fault
// - temperature snapshot taken at temperature fault
// - hold delay steps of interval times 100us
// - spread bit propagates channel fault to others
`timescale 1ns/10ps
module smrfc_top
  import smrfc_pkg::*;
#(
  parameter int unsigned RESET_STEP_CYC = RESET_STEP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic [15:0] cmd_rdata_out,
  input wire logic [15:0] monitor_sample_interval_in,
  input wire logic [7:0] input_filter_control_in,
  input wire logic [NUM_CH-1:0][7:0] channel_output_mode_in,
  input wire logic closed_loop_voltage_trim_in,
  input wire logic [NUM_CH-1:0][15:0] sense_input_in,
  input wire logic [NUM_CH-1:0][15:0] uv_limit_in,
  input wire logic [NUM_CH-1:0][15:0] ov_limit_in,
  input wire logic [15:0] temperature_in,
  input wire logic [NUM_CH-1:0] chan_at_target_in,
  input wire logic [NUM_CH-1:0] chan_enabled_in,
  input wire logic [NUM_CH-1:0] vfault_in,
  input wire logic temp_fault_in,
  output logic [NUM_CH-1:0] chan_fault_out,
  output logic conv_done_out,
  output logic seq_done_out,
  output logic dac_update_out,
  output logic reset_o_out,
  output logic reset_oe_out
);
  typedef struct packed {
    logic [15:0] gap_interval;
    logic [15:0] dac_count;
    logic [7:0] reset_select;
    logic [15:0] hold_delay;
    logic [15:0] fault_flags;
    logic [15:0] fault_vsnap;
    logic [15:0] fault_tsnap;
    logic [NUM_CH-1:0][15:0] result;
    smrfc_rst_state_type rst_st;
    logic [31:0] step_cnt;
    logic [15:0] delay_cnt;
    logic reset_drive;
    logic [NUM_CH-1:0] chan_fault;
    logic [15:0] rdata;
  } smrfc_regs_type;

  smrfc_regs_type r, nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  smrfc_seq_if seq_link();

  logic [NUM_CH-1:0] spread_src;
  logic [NUM_CH-1:0] fault_eff;
  logic [15:0] flags_now;
  logic [15:0] vfault_value;
  logic sel_valid;
  logic [1:0] sel_ch;
  logic sel_ok;
  logic [31:0] step_target;
  logic step_en;

  // reset is released through two flops so every flop leaves reset on one edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign seq_link.gap_interval = r.gap_interval;
  assign seq_link.dac_count = r.dac_count;
  assign seq_link.filter_on = ~input_filter_control_in[FILTER_OFF_BIT];
  assign seq_link.trim_on = closed_loop_voltage_trim_in;

  smrfc_sequencer u_seq (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .link(seq_link)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign spread_src[g] = vfault_in[g] & channel_output_mode_in[g][SPREAD_ENABLE_BIT];
      assign flags_now[g*FLAG_STRIDE+UNDER_FLAG_BIT] = r.result[g] < uv_limit_in[g];
      assign flags_now[g*FLAG_STRIDE+OVER_FLAG_BIT] = r.result[g] > ov_limit_in[g];
      assign flags_now[g*FLAG_STRIDE+FLAG_STRIDE-1:g*FLAG_STRIDE+UNDER_FLAG_BIT+1] = '0;
    end
  endgenerate

  // a spreading fault reaches every channel, its own included
  assign fault_eff = vfault_in | {NUM_CH{|spread_src}};

  // lowest faulting channel supplies the voltage snapshot
  always_comb begin
    vfault_value = r.result[0];
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (vfault_in[i]) begin
        vfault_value = r.result[i];
      end
    end
  end

  assign sel_valid = (r.reset_select <= LAST_CHANNEL);
  assign sel_ch = r.reset_select[1:0];
  assign sel_ok = sel_valid & chan_at_target_in[sel_ch] & chan_enabled_in[sel_ch]
                  & ~fault_eff[sel_ch];
  // interval of zero is taken as one step unit
  assign step_target = (monitor_sample_interval_in == 16'h0000) ? 32'(RESET_STEP_CYC) :
                       32'(monitor_sample_interval_in) * 32'(RESET_STEP_CYC);
  assign step_en = (r.step_cnt + 32'h00000001 >= step_target);

  always_comb begin
    nxt = r;
    nxt.chan_fault = fault_eff;
    if (cmd_wr_in) begin
      case (cmd_code_in)
        CMD_ADC_GAP_INTERVAL: nxt.gap_interval = cmd_wdata_in;
        CMD_DAC_UPDATE_SAMPLE_COUNT: nxt.dac_count = cmd_wdata_in;
        CMD_RESET_SOURCE_SELECT: nxt.reset_select = cmd_wdata_in[7:0];
        CMD_RESET_HOLD_DELAY: nxt.hold_delay = cmd_wdata_in;
        default: nxt.hold_delay = r.hold_delay;
      endcase
    end
    if (seq_link.seq_done) begin
      nxt.result = sense_input_in;
    end
    if (|vfault_in) begin
      nxt.fault_flags = flags_now;
      nxt.fault_vsnap = vfault_value;
    end
    if (temp_fault_in) begin
      nxt.fault_tsnap = temperature_in;
    end
    case (r.rst_st)
      RST_HOLD: begin
        nxt.reset_drive = 1'b1;
        nxt.step_cnt = 32'h00000000;
        nxt.delay_cnt = 16'h0000;
        if (sel_ok) begin
          nxt.rst_st = RST_WAIT;
        end
      end
      RST_WAIT: begin
        nxt.reset_drive = 1'b1;
        if (!sel_ok) begin
          nxt.rst_st = RST_HOLD;
        end else if (r.delay_cnt >= r.hold_delay) begin
          nxt.rst_st = RST_RELEASED;
          nxt.reset_drive = 1'b0;
        end else if (step_en) begin
          nxt.step_cnt = 32'h00000000;
          nxt.delay_cnt = r.delay_cnt + 16'h0001;
        end else begin
          nxt.step_cnt = r.step_cnt + 32'h00000001;
        end
      end
      RST_RELEASED: begin
        nxt.reset_drive = 1'b0;
        if (!sel_ok) begin
          nxt.rst_st = RST_HOLD;
          nxt.reset_drive = 1'b1;
        end
      end
      default: begin
        nxt.rst_st = RST_HOLD;
        nxt.reset_drive = 1'b1;
      end
    endcase
    case (cmd_code_in)
      CMD_ADC_GAP_INTERVAL: nxt.rdata = r.gap_interval;
      CMD_DAC_UPDATE_SAMPLE_COUNT: nxt.rdata = r.dac_count;
      CMD_RESET_SOURCE_SELECT: nxt.rdata = {8'h00, r.reset_select};
      CMD_RESET_HOLD_DELAY: nxt.rdata = r.hold_delay;
      CMD_FAULT_CAUSE_FLAGS: nxt.rdata = r.fault_flags;
      CMD_FAULT_VOLTAGE_SNAPSHOT: nxt.rdata = r.fault_vsnap;
      CMD_FAULT_TEMPERATURE_SNAPSHOT: nxt.rdata = r.fault_tsnap;
      default: nxt.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.gap_interval <= GAP_INTERVAL_RST;
      r.dac_count <= DAC_COUNT_RST;
      r.reset_select <= RESET_SELECT_RST;
      r.hold_delay <= HOLD_DELAY_RST;
      r.rst_st <= RST_HOLD;
      r.reset_drive <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  // open drain: only ever pulls low
  assign reset_o_out = 1'b0;
  // the synchronised reset also pulls the pin so it is low until the sync releases
  assign reset_oe_out = r.reset_drive | ~rst_n;
  assign cmd_rdata_out = r.rdata;
  assign chan_fault_out = r.chan_fault;
  assign conv_done_out = seq_link.conv_done;
  assign seq_done_out = seq_link.seq_done;
  assign dac_update_out = seq_link.dac_update;
endmodule // smrfc_top

// >>> smrfc_properties.sv
// port-level checks for the supply monitor, reset output and fault capture
`timescale 1ns/10ps
module smrfc_properties
  import smrfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic closed_loop_voltage_trim_in,
  input wire logic [NUM_CH-1:0][7:0] channel_output_mode_in,
  input wire logic [NUM_CH-1:0] chan_enabled_in,
  input wire logic [NUM_CH-1:0] vfault_in,
  input wire logic [NUM_CH-1:0] chan_fault_out,
  input wire logic conv_done_out,
  input wire logic seq_done_out,
  input wire logic dac_update_out,
  input wire logic reset_o_out,
  input wire logic reset_oe_out
);
  logic [2:0] live_r;
  logic [7:0] sel_r;
  logic [NUM_CH-1:0] spread;
  // shadow of the reset source select, updated on the same edge as the device copy
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live_r <= 3'h0;
      sel_r <= 8'hff;
    end else begin
      live_r <= {live_r[1:0], 1'b1};
      if (cmd_wr_in && cmd_code_in == CMD_RESET_SOURCE_SELECT) begin
        sel_r <= cmd_wdata_in[7:0];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      spread[i] = channel_output_mode_in[i][SPREAD_ENABLE_BIT];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  od_data_low_a: assert property (reset_o_out == 1'b0)
    else $error("reset pin data not low");
  bad_select_hold_a: assert property ((sel_r > LAST_CHANNEL) [*2] |-> reset_oe_out)
    else $error("reset released with invalid select");
  chan_off_low_a: assert property (sel_r <= LAST_CHANNEL && !chan_enabled_in[sel_r[1:0]]
    |-> ##[1:2] reset_oe_out) else $error("reset not pulled low on disabled channel");
  fault_spread_a: assert property (live_r[2] && |(vfault_in & spread) |=> &chan_fault_out)
    else $error("spread fault missing on some channel");
  own_fault_a: assert property (live_r[2] && spread == 4'h0 |=> chan_fault_out == $past(vfault_in))
    else $error("unspread fault leaked or lost");
  dac_with_seq_a: assert property (dac_update_out |-> seq_done_out)
    else $error("trim update outside sequence end");
  trim_off_quiet_a: assert property (!closed_loop_voltage_trim_in [*3] |-> !dac_update_out)
    else $error("trim update with trim mode off");
  conv_spacing_a: assert property (conv_done_out |=> !conv_done_out [*8])
    else $error("conversions closer than one conversion time");
  seq_single_a: assert property (seq_done_out |=> !seq_done_out [*8])
    else $error("sequence end pulses too close");
  flag_reserved_a: assert property ($past(cmd_code_in) == CMD_FAULT_CAUSE_FLAGS
    |-> (cmd_rdata_out & 16'hcccc) == 16'h0000) else $error("reserved flag bits set");
  cover property (dac_update_out);
  cover property ($fell(reset_oe_out));
  cover property (&chan_fault_out);
endmodule // smrfc_properties

bind smrfc_top smrfc_properties u_props (.clk_in, .rst_n_in, .cmd_wr_in, .cmd_code_in,
  .cmd_wdata_in, .cmd_rdata_out, .closed_loop_voltage_trim_in, .channel_output_mode_in,
  .chan_enabled_in, .vfault_in, .chan_fault_out, .conv_done_out, .seq_done_out,
  .dac_update_out, .reset_o_out, .reset_oe_out);

// >>> smrfc_host_model.sv
// system host model driving the command port and per-channel mode settings
`timescale 1ns/10ps
module smrfc_host_model
  import smrfc_pkg::*;
(
  input wire logic clk_in,
  output logic cmd_wr_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_wdata_out,
  output logic rd_mark_out,
  output logic [NUM_CH-1:0][7:0] mode_out
);
  initial begin
    cmd_wr_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_wdata_out = 16'h0000;
    rd_mark_out = 1'b0;
    mode_out = '0;
  end
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk_in) #1;
    cmd_wr_out = 1'b1;
    cmd_code_out = code;
    cmd_wdata_out = data;
    @(posedge clk_in) #1;
    cmd_wr_out = 1'b0;
    // data is not held after the strobe, so a late sample shows garbage
    cmd_wdata_out = ~data;
  endtask
  task automatic rd(input logic [7:0] code);
    @(posedge clk_in) #1;
    cmd_code_out = code;
    rd_mark_out = 1'b1;
    @(posedge clk_in) #1;
    rd_mark_out = 1'b0;
  endtask
  task automatic spread(input logic on);
    for (int i = 0; i < NUM_CH; i++) begin
      mode_out[i][SPREAD_ENABLE_BIT] = on;
    end
  endtask
endmodule // smrfc_host_model

// >>> smrfc_tb_top.sv
// self-checking bench for the supply monitor, reset output and fault capture
`timescale 1ns/10ps
module smrfc_tb_top
  import smrfc_pkg::*;
;
  localparam int STEP = 10;
  logic clk_in, rst_n_in, cmd_wr_in, rd_mark, closed_loop_voltage_trim_in;
  logic rd_seen = 1'b0;
  logic [7:0] cmd_code_in, input_filter_control_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, monitor_sample_interval_in, temperature_in, gapn;
  logic [NUM_CH-1:0][7:0] channel_output_mode_in;
  logic [NUM_CH-1:0][15:0] sense_input_in, uv_limit_in, ov_limit_in;
  logic [NUM_CH-1:0] chan_at_target_in, chan_enabled_in, vfault_in, chan_fault_out;
  logic temp_fault_in, conv_done_out, seq_done_out, dac_update_out, reset_o_out, reset_oe_out;
  logic [15:0] exp_q[$];
  int error_cnt, checks_done, cyc, len, convs, seqs, k, cnt, n;
  smrfc_top #(.RESET_STEP_CYC(STEP)) dut (.clk_in, .rst_n_in, .cmd_wr_in, .cmd_code_in,
    .cmd_wdata_in, .cmd_rdata_out, .monitor_sample_interval_in, .input_filter_control_in,
    .channel_output_mode_in, .closed_loop_voltage_trim_in, .sense_input_in, .uv_limit_in,
    .ov_limit_in, .temperature_in, .chan_at_target_in, .chan_enabled_in, .vfault_in,
    .temp_fault_in, .chan_fault_out, .conv_done_out, .seq_done_out, .dac_update_out,
    .reset_o_out, .reset_oe_out);
  smrfc_host_model host (.clk_in, .cmd_wr_out(cmd_wr_in), .cmd_code_out(cmd_code_in),
    .cmd_wdata_out(cmd_wdata_in), .rd_mark_out(rd_mark), .mode_out(channel_output_mode_in));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(c);
  endtask
  // cycles and pulses from one sequence end (or trim update) to the next
  task automatic span(input bit on_dac);
    n = 0;
    len = 0;
    convs = 0;
    seqs = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (!(on_dac ? dac_update_out : seq_done_out) && n < 20000);
    do begin
      @(posedge clk_in);
      #1;
      len++;
      convs += conv_done_out;
      seqs += seq_done_out;
    end while (!(on_dac ? dac_update_out : seq_done_out) && len < 20000);
  endtask
  task automatic pulse(input logic [NUM_CH-1:0] v);
    @(posedge clk_in) #1;
    vfault_in = v;
    temp_fault_in = 1'b1;
    @(posedge clk_in) #1;
    vfault_in = '0;
    temp_fault_in = 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rd_seen) chk("read data", exp_q.pop_front(), cmd_rdata_out);
    rd_seen <= rd_mark;
    cyc++;
    if (cyc == 70000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h1679b20b));
    rst_n_in = 1'b0;
    monitor_sample_interval_in = 16'h0003;
    input_filter_control_in = 8'h00;
    closed_loop_voltage_trim_in = 1'b0;
    {sense_input_in, uv_limit_in, ov_limit_in, temperature_in} = '0;
    chan_at_target_in = '1;
    chan_enabled_in = '1;
    vfault_in = '0;
    temp_fault_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    chk("powerup reset", 16'h0001, {15'h0, reset_oe_out});
    chk("reset pin data", 16'h0000, {15'h0, reset_o_out});
    repeat (3) @(posedge clk_in);
    rd(CMD_ADC_GAP_INTERVAL, 16'h0064);
    rd(8'h00, 16'h0000);
    host.wr(CMD_FAULT_CAUSE_FLAGS, 16'hffff);
    rd(CMD_FAULT_CAUSE_FLAGS, 16'h0000);
    for (int f = 0; f < 2; f++) begin
      gapn = 16'($urandom_range(4, 1));
      input_filter_control_in = f ? 8'h02 : 8'h00;
      k = f ? 1 : 4;
      host.wr(CMD_ADC_GAP_INTERVAL, gapn);
      rd(CMD_ADC_GAP_INTERVAL, gapn);
      span(1'b0);
      span(1'b0);
      chk("sequence cycles", 16'(TICK_CYCLES * (CONV_TICKS + gapn + 4 * (gapn + CONV_TICKS * k))),
        16'(len));
      chk("conversions", 16'(1 + 4 * k), 16'(convs));
    end
    closed_loop_voltage_trim_in = 1'b1;
    cnt = $urandom_range(3, 2);
    host.wr(CMD_DAC_UPDATE_SAMPLE_COUNT, 16'(cnt));
    span(1'b1);
    span(1'b1);
    chk("trim samples", 16'(cnt), 16'(seqs));
    chk("trim period", 16'(cnt * TICK_CYCLES * (35 + 5 * gapn)), 16'(len));
    closed_loop_voltage_trim_in = 1'b0;
    host.wr(CMD_RESET_HOLD_DELAY, 16'h0002);
    host.wr(CMD_RESET_SOURCE_SELECT, 16'h0001);
    n = 0;
    while (reset_oe_out && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("hold release", 16'h0001, 16'(n >= 59 && n <= 66));
    rd(CMD_RESET_SOURCE_SELECT, 16'h0001);
    chan_enabled_in[1] = 1'b0;
    repeat (3) @(posedge clk_in);
    chk("disabled channel", 16'h0001, {15'h0, reset_oe_out});
    #1;
    chan_enabled_in[1] = 1'b1;
    repeat (80) @(posedge clk_in);
    chk("re-release", 16'h0000, {15'h0, reset_oe_out});
    host.wr(CMD_RESET_SOURCE_SELECT, 16'($urandom_range(255, 4)));
    repeat (100) @(posedge clk_in);
    chk("invalid select", 16'h0001, {15'h0, reset_oe_out});
    #1;
    uv_limit_in = {4{16'h1000}};
    ov_limit_in = {4{16'h3000}};
    sense_input_in = {16'($urandom_range(16'hffff, 16'h3001)), 16'($urandom_range(16'h0fff)),
      16'h3000, 16'h1000};
    temperature_in = 16'($urandom);
    span(1'b0);
    pulse(4'b0100);
    chk("own fault", 16'h0004, {12'h0, chan_fault_out});
    rd(CMD_FAULT_CAUSE_FLAGS, 16'h1200);
    rd(CMD_FAULT_VOLTAGE_SNAPSHOT, sense_input_in[2]);
    rd(CMD_FAULT_TEMPERATURE_SNAPSHOT, temperature_in);
    exp_q.push_back(sense_input_in[2]);
    exp_q.push_back(temperature_in);
    sense_input_in = '1;
    temperature_in = ~temperature_in;
    span(1'b0);
    host.rd(CMD_FAULT_VOLTAGE_SNAPSHOT);
    host.rd(CMD_FAULT_TEMPERATURE_SNAPSHOT);
    host.spread(1'b1);
    pulse(4'b0001);
    chk("spread fault", 16'h000f, {12'h0, chan_fault_out});
    repeat (3) @(posedge clk_in);
    wrap_up();
  end
endmodule // smrfc_tb_top
